// File: hdl/lvr_pkg.sv
package lvr_pkg;
  // link shape
  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam int WORD_W = LANES * SLOTS;
  // timing
  localparam int SYS_CLK_MHZ = 100;
  localparam int PLL_LOCK_MS = 10;
  localparam int LOCK_CYCLES = PLL_LOCK_MS * 1000 * SYS_CLK_MHZ;
  localparam int LOSS_CYCLES = 256;
  // counter and synchroniser widths
  localparam int CNT_W = 9;
  localparam int ACC_W = 16;
  localparam int SYNC_W = 2 * LANES + 3;
  // buffering
  localparam int FIFO_DEPTH = 8;
  // phase step per system cycle: two per serial slot
  localparam logic [ACC_W-1:0] PHASE_STEP = 16'h000E;
  localparam logic [ACC_W-1:0] HALF_SLOTS = 16'h0007;
  localparam logic [CNT_W-1:0] LOSS_COUNT = 9'h100;
  localparam logic [2:0] SLOT_DONE = 3'h7;
  // link states
  typedef enum logic [1:0] {
    LVR_DOWN = 2'b00,
    LVR_WAIT = 2'b01,
    LVR_LOCKING = 2'b10,
    LVR_LOCKED = 2'b11
  } lvr_link_state_t;
endpackage

// File: hdl/lvr_fifo_if.sv
`timescale 1ns/10ps
interface lvr_fifo_if #(parameter int WIDTH = 28) ();
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic flush;
  modport fifo (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data
  );
endinterface

// File: hdl/lvr_stream_fifo.sv
`timescale 1ns/10ps
module lvr_stream_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  lvr_fifo_if.fifo port
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  wire do_write;
  wire do_read;

  // handshakes and flags
  assign port.wr_ready = (count != (PTR_W+1)'(DEPTH)) && !port.flush;
  assign port.rd_valid = (count != '0) && !port.flush;
  assign port.rd_data = mem[rd_ptr];
  assign do_write = port.wr_valid && port.wr_ready;
  assign do_read = port.rd_valid && port.rd_ready;

  // storage, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (do_write) mem[wr_ptr] <= port.wr_data;
  end

  // pointers and fill count
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (port.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_write) wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_read) rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PTR_W+1)'(do_write) - (PTR_W+1)'(do_read);
    end
  end
endmodule // lvr_stream_fifo

// File: hdl/lvr_lvds_28bit_receiver.sv
// How it works
// - four differential data lanes plus clock lane
// - 28 parallel outputs, once per period
// - regenerated clock rises mid data stability
// - powerdown low forces all outputs low
// - undriven data lane reads as high
// - undriven data, live clock: data outputs high
// - clock lost: data outputs hold last
// - undriven clock: regenerated clock held high, low if no clock since reset or powerdown release
// - exactly five lanes: four data, one clock
// - seven serial bits per clock period
// - lock within 10 ms after release
// - two periods latency to parallel output
`timescale 1ns/10ps
module lvr_lvds_28bit_receiver #(
  parameter int LOCK_CYCLES = lvr_pkg::LOCK_CYCLES,
  parameter int FIFO_DEPTH = lvr_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [lvr_pkg::LANES-1:0] serial_data_lane_p_in,
  input wire logic [lvr_pkg::LANES-1:0] serial_data_lane_n_in,
  input wire logic forwarded_clock_p_in,
  input wire logic forwarded_clock_n_in,
  input wire logic powerdown_n_in,
  output logic [lvr_pkg::WORD_W-1:0] parallel_data_out,
  output logic regenerated_clock_out,
  output logic link_locked_out
);
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int W = lvr_pkg::WORD_W;

  // failsafe receiver: equal legs mean floating or only terminated
  function automatic logic rx_level(input logic p, input logic n);
    return (p == n) ? 1'b1 : p;
  endfunction

  logic [lvr_pkg::SYNC_W-1:0] sync_a;
  logic [lvr_pkg::SYNC_W-1:0] sync_b;
  logic fclk_prev;
  logic [lvr_pkg::CNT_W-1:0] cnt;
  logic [lvr_pkg::CNT_W-1:0] period;
  logic [lvr_pkg::ACC_W-1:0] pair;
  logic [lvr_pkg::ACC_W-1:0] acc;
  logic [lvr_pkg::ACC_W-1:0] target;
  logic [2:0] slot;
  logic [W-1:0] word;
  logic word_full;
  logic [W-1:0] push_word;
  logic push_valid;
  logic [LOCK_W-1:0] lock_cnt;
  lvr_pkg::lvr_link_state_t state;
  lvr_pkg::lvr_link_state_t next_state;
  lvr_fifo_if #(.WIDTH(W)) fq ();

  wire [lvr_pkg::LANES-1:0] lane_p;
  wire [lvr_pkg::LANES-1:0] lane_n;
  wire [lvr_pkg::LANES-1:0] lane_bit;
  wire pd_n;
  wire fclk_failsafe;
  wire fclk;
  wire rise;
  wire lost;
  wire sample;
  wire locked;
  wire half_reached;
  wire lock_done;
  wire [lvr_pkg::ACC_W-1:0] period_w;
  wire [lvr_pkg::ACC_W-1:0] period_new;
  wire [lvr_pkg::ACC_W-1:0] step2;
  wire [lvr_pkg::ACC_W-1:0] pair_new;
  wire [lvr_pkg::ACC_W-1:0] pair_now;
  wire [lvr_pkg::ACC_W-1:0] elapsed;
  wire [lvr_pkg::ACC_W-1:0] thr_now;
  wire [lvr_pkg::ACC_W-1:0] next_target;
  wire [2:0] slot_now;
  wire full_now;

  // two-flop synchroniser for the powerdown, clock and data lane inputs
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {powerdown_n_in, forwarded_clock_p_in, forwarded_clock_n_in,
                 serial_data_lane_p_in, serial_data_lane_n_in};
      sync_b <= sync_a;
    end
  end

  // lane decode from synchronised legs
  assign pd_n = sync_b[lvr_pkg::SYNC_W-1];
  assign lane_p = sync_b[2*lvr_pkg::LANES-1:lvr_pkg::LANES];
  assign lane_n = sync_b[lvr_pkg::LANES-1:0];
  assign fclk_failsafe = (sync_b[lvr_pkg::SYNC_W-2] == sync_b[lvr_pkg::SYNC_W-3]);
  assign fclk = rx_level(sync_b[lvr_pkg::SYNC_W-2], sync_b[lvr_pkg::SYNC_W-3]);
  for (genvar l = 0; l < lvr_pkg::LANES; l++) begin : g_lane
    assign lane_bit[l] = rx_level(lane_p[l], lane_n[l]);
  end

  // edge, loss and sampling decisions
  assign rise = fclk && !fclk_prev && !fclk_failsafe;
  assign lost = fclk_failsafe || (cnt == lvr_pkg::LOSS_COUNT);
  assign step2 = lvr_pkg::PHASE_STEP + lvr_pkg::PHASE_STEP;
  assign period_w = lvr_pkg::ACC_W'(period);
  assign period_new = lvr_pkg::ACC_W'(cnt) + 16'h0001;
  // two periods summed, so one-cycle quantising does not skew slots
  assign pair_new = period_w + period_new;
  assign pair_now = rise ? pair_new : pair;
  assign elapsed = rise ? '0 : acc;
  assign thr_now = rise ? pair_new : target;
  assign slot_now = rise ? 3'h0 : slot;
  assign full_now = rise ? 1'b0 : word_full;
  // slot k once 28*(cycles+1) reaches (2k+1) times the period pair
  assign sample = !full_now && (elapsed + step2 >= thr_now);
  assign next_target = thr_now + pair_now + pair_now;
  assign half_reached = acc >= (pair * lvr_pkg::HALF_SLOTS);
  assign locked = (state == lvr_pkg::LVR_LOCKED);
  assign lock_done = (lock_cnt == LOCK_W'(LOCK_CYCLES - 1));

  // period measurement and phase accumulator
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fclk_prev <= 1'b1;
      cnt <= lvr_pkg::LOSS_COUNT;
      period <= '0;
      pair <= '0;
      acc <= '0;
    end else begin
      fclk_prev <= fclk;
      if (rise) begin
        cnt <= '0;
        period <= (cnt == lvr_pkg::LOSS_COUNT) ? cnt : cnt + 1'b1;
        pair <= pair_new;
        acc <= step2;
      end else if (cnt != lvr_pkg::LOSS_COUNT) begin
        cnt <= cnt + 1'b1;
        acc <= acc + step2;
      end
    end
  end

  // slot capture; slot zero may fall on the rise itself
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      target <= '1;
      slot <= '0;
      word <= '0;
      word_full <= 1'b0;
    end else if (rise || sample) begin
      if (sample) begin
        for (int l = 0; l < lvr_pkg::LANES; l++) begin
          word[l*lvr_pkg::SLOTS + int'(slot_now)] <= lane_bit[l];
        end
      end
      target <= sample ? next_target : thr_now;
      slot <= slot_now + {2'b00, sample};
      word_full <= full_now ||
                   (sample && (slot_now == lvr_pkg::SLOT_DONE - 3'h1));
    end
  end

  // hand finished word to the fifo; stalls while fifo is full
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      push_word <= '0;
      push_valid <= 1'b0;
    end else if (!locked) begin
      push_valid <= 1'b0;
    end else if (rise && word_full && (!push_valid || fq.wr_ready)) begin
      push_word <= word;
      push_valid <= 1'b1;
    end else if (fq.wr_ready) begin
      push_valid <= 1'b0;
    end
  end

  assign fq.wr_valid = push_valid;
  assign fq.wr_data = push_word;
  assign fq.rd_ready = locked && rise;
  assign fq.flush = !locked;

  lvr_stream_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .port(fq.fifo)
  );

  // link state: powerdown, waiting for clock, locking, locked
  always_comb begin
    next_state = state;
    case (state)
      lvr_pkg::LVR_DOWN: if (pd_n && !lost) next_state = lvr_pkg::LVR_LOCKING;
      lvr_pkg::LVR_WAIT: if (!lost) next_state = lvr_pkg::LVR_LOCKING;
      lvr_pkg::LVR_LOCKING: begin
        if (lost) next_state = lvr_pkg::LVR_WAIT;
        else if (lock_done) next_state = lvr_pkg::LVR_LOCKED;
      end
      lvr_pkg::LVR_LOCKED: if (lost) next_state = lvr_pkg::LVR_WAIT;
      default: next_state = lvr_pkg::LVR_DOWN;
    endcase
    if (!pd_n) next_state = lvr_pkg::LVR_DOWN;
  end

  // state register and lock timer
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= lvr_pkg::LVR_DOWN;
      lock_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state != lvr_pkg::LVR_LOCKING) lock_cnt <= '0;
      else lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // outputs: low in powerdown; on loss data held, clock high, lock low; updated once per period
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      parallel_data_out <= '0;
      regenerated_clock_out <= 1'b0;
      link_locked_out <= 1'b0;
    end else begin
      link_locked_out <= (next_state == lvr_pkg::LVR_LOCKED);
      if (state == lvr_pkg::LVR_DOWN) begin
        parallel_data_out <= '0;
        regenerated_clock_out <= 1'b0;
      end else if (!locked) begin
        regenerated_clock_out <= 1'b1;
      end else if (rise) begin
        if (fq.rd_valid) parallel_data_out <= fq.rd_data;
        regenerated_clock_out <= 1'b0;
      end else if (half_reached) begin
        regenerated_clock_out <= 1'b1;
      end
    end
  end
endmodule // lvr_lvds_28bit_receiver

// File: verif/lvr_rx_monitor.sv
`timescale 1ns/10ps
module lvr_rx_monitor #(
  parameter int LOCK_CYCLES = 200
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic forwarded_clock_p_in,
  input wire logic forwarded_clock_n_in,
  input wire logic powerdown_n_in,
  input wire logic [lvr_pkg::WORD_W-1:0] parallel_data_out,
  input wire logic regenerated_clock_out,
  input wire logic link_locked_out
);
  // short aliases of the watched outputs
  wire logic rc = regenerated_clock_out;
  wire logic lk = link_locked_out;
  wire logic [lvr_pkg::WORD_W-1:0] dat = parallel_data_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // powerdown held long enough to reach the outputs
  sequence s_pd_held;
    !powerdown_n_in [*5];
  endsequence
  // start of a locked strobe period
  sequence s_fall;
    $fell(rc) && lk;
  endsequence
  a_reset_quiet: assert property (
    $rose(reset_n_in) |-> dat == '0 && !rc && !lk)
    else $error("outputs not quiet after reset");
  a_pd_clears_out: assert property (
    s_pd_held |-> dat == '0 && !rc && !lk)
    else $error("outputs not low in powerdown");
  a_data_at_fall: assert property (
    $changed(dat) |-> $fell(rc) || (dat == '0 && !rc))
    else $error("data moved off the clock fall");
  a_low_half: assert property (
    s_fall |=> (!rc || !lk) [*4])
    else $error("clock low phase too short");
  a_high_half: assert property (
    $rose(rc) && lk |=> (rc || !lk) [*4])
    else $error("clock high phase too short");
  a_strobe_period: assert property (
    s_fall |-> ##[1:14] ($fell(rc) || !lk))
    else $error("no word in one period");
  a_data_holds: assert property (
    s_fall |=> ($stable(dat) || !lk) [*8])
    else $error("word not held for the period");
  a_lost_clk_hold: assert property (
    (forwarded_clock_p_in == forwarded_clock_n_in) [*6] |-> $stable(dat))
    else $error("data moved without a clock");
endmodule // lvr_rx_monitor
bind lvr_lvds_28bit_receiver lvr_rx_monitor #(.LOCK_CYCLES(LOCK_CYCLES))
  i_mon (.clk_sys_in, .reset_n_in, .forwarded_clock_p_in,
  .forwarded_clock_n_in, .powerdown_n_in, .parallel_data_out,
  .regenerated_clock_out, .link_locked_out);

// File: verif/lvr_tx_model.sv
`timescale 1ns/10ps
module lvr_tx_model #(
  parameter realtime PERIOD = 125.0
) (
  input wire logic [lvr_pkg::WORD_W-1:0] word_in,
  input wire logic data_on_in,
  input wire logic clk_on_in,
  output logic [lvr_pkg::LANES-1:0] lane_p_out,
  output logic [lvr_pkg::LANES-1:0] lane_n_out,
  output logic clk_p_out,
  output logic clk_n_out,
  output logic [lvr_pkg::WORD_W-1:0] sent_out,
  output logic tick_out
);
  logic [lvr_pkg::WORD_W-1:0] w;
  logic on;
  logic d;
  // one period: clock high four slots, equal legs when undriven
  initial begin
    tick_out = 1'b0;
    sent_out = '0;
    #3.3;
    forever begin
      on = clk_on_in;
      d = data_on_in;
      w = d ? word_in : '1;
      if (on) begin
        sent_out = w;
        tick_out = ~tick_out;
      end
      for (int s = 0; s < lvr_pkg::SLOTS; s++) begin
        clk_p_out = on ? (s < 4) : 1'b1;
        clk_n_out = on ? (s >= 4) : 1'b1;
        for (int l = 0; l < lvr_pkg::LANES; l++) begin
          lane_p_out[l] = d ? w[l*7+s] : s[0];
          lane_n_out[l] = d ? !w[l*7+s] : s[0];
        end
        #(PERIOD / 7);
      end
    end
  end
endmodule // lvr_tx_model

// File: verif/lvr_lvds_28bit_receiver_tb.sv
`timescale 1ns/10ps
module lvr_lvds_28bit_receiver_tb;
  localparam int W = lvr_pkg::WORD_W;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic pd_n = 1'b0;
  logic data_on = 1'b1;
  logic clk_on = 1'b1;
  logic rc_q = 1'b0;
  logic [W-1:0] tx_word = '0;
  logic [W-1:0] last = '0;
  logic [31:0] seed = 32'h0000003A;
  logic [W-1:0] q[$];
  int n_str = 0;
  int err_count = 0;
  int total_checks = 0;
  wire logic [lvr_pkg::LANES-1:0] lp;
  wire logic [lvr_pkg::LANES-1:0] ln;
  wire logic cp, cn, tick, rc, lk;
  wire logic [W-1:0] sent;
  wire logic [W-1:0] dat;
  // all receiver outputs are connected, none left open
  lvr_lvds_28bit_receiver #(.LOCK_CYCLES(200)) i_lvr_lvds_28bit_receiver (
    .clk_sys_in, .reset_n_in, .serial_data_lane_p_in(lp),
    .serial_data_lane_n_in(ln), .forwarded_clock_p_in(cp),
    .forwarded_clock_n_in(cn), .powerdown_n_in(pd_n),
    .parallel_data_out(dat), .regenerated_clock_out(rc),
    .link_locked_out(lk));
  lvr_tx_model i_lvr_tx_model (.word_in(tx_word), .data_on_in(data_on),
    .clk_on_in(clk_on), .lane_p_out(lp), .lane_n_out(ln), .clk_p_out(cp),
    .clk_n_out(cn), .sent_out(sent), .tick_out(tick));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wait_lock();
    for (int i = 0; i < 300 && lk !== 1'b1; i++) @(posedge clk_sys_in);
    check(lk, 1'b1);
  endtask
  always #5 clk_sys_in = ~clk_sys_in;
  // random words, top bit tied low as an unused input
  always @(posedge clk_sys_in) begin
    seed <= lfsr(seed);
    tx_word <= {1'b0, seed[W-2:0]};
  end
  // reference queue of words put on the link
  always @(tick) q.push_back(sent);
  // each strobed word after the first of a lock against the oldest word sent
  always @(posedge clk_sys_in) begin
    rc_q <= rc;
    if (lk !== 1'b1) n_str <= 0;
    else if (rc && !rc_q) begin
      n_str <= n_str + 1;
      if (n_str == 1)
        while (q.size() > 0 && q[0] !== dat) void'(q.pop_front());
      if (n_str >= 1) begin
        check(dat, q.size() > 0 ? q.pop_front() : ~dat);
        check(W'(q.size()), W'(2));
      end
    end
    if (lk === 1'b1) last <= dat;
  end
  // watchdog against a hung link
  initial begin
    cyc(4000);
    err_count++;
    finish_test();
  end
  // main sequence
  initial begin
    cyc(12);
    reset_n_in <= 1'b1;
    cyc(20);
    check(dat, '0);
    check(rc, 1'b0);
    pd_n <= 1'b1;
    cyc(150);
    check(lk, 1'b0);
    check(dat, '0);
    wait_lock();
    cyc(400);
    data_on <= 1'b0;
    cyc(200);
    data_on <= 1'b1;
    cyc(200);
    clk_on <= 1'b0;
    cyc(300);
    check(rc, 1'b1);
    check(dat, last);
    clk_on <= 1'b1;
    wait_lock();
    cyc(300);
    pd_n <= 1'b0;
    cyc(10);
    check(dat, '0);
    check(W'({rc, lk}), '0);
    finish_test();
  end
endmodule // lvr_lvds_28bit_receiver_tb
